// File: design/smc_params.svh
// timing constants for the sdram module command controller
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH
`define SMC_CLK_PERIOD_PS 20000
`define SMC_POWERUP_WAIT_NS 100000
`define SMC_POWERUP_WAIT_CYC ((`SMC_POWERUP_WAIT_NS * 1000 + `SMC_CLK_PERIOD_PS - 1) / `SMC_CLK_PERIOD_PS)
`define SMC_COLUMN_TO_COLUMN_GAP 1
`define SMC_WRITE_TO_ACTIVATE_GAP 5
`define SMC_LAST_WRITE_TO_PRECHARGE_GAP 2
`define SMC_LAST_WRITE_TO_STOP_GAP 1
`define SMC_LAST_WRITE_TO_COLUMN_GAP 1
`define SMC_MODE_LOAD_GAP 3
`define SMC_SELF_REFRESH_EXIT_GAP_NS 80
`define SMC_SELF_REFRESH_EXIT_CYC ((`SMC_SELF_REFRESH_EXIT_GAP_NS * 1000 + `SMC_CLK_PERIOD_PS - 1) / `SMC_CLK_PERIOD_PS)
`define SMC_SELF_REFRESH_MIN_TOGGLES 2
`define SMC_WAKE_REFRESHES 2
`define SMC_GAP_W 4
`define SMC_AUTO_PRE_BIT 10
`endif

// File: design/smc_pkg.sv
// types for the sdram module command controller
`default_nettype none
package smc_pkg;
   typedef enum logic [2:0] {
      SMC_CMD_NOP,
      SMC_CMD_ACTIVE,
      SMC_CMD_READ,
      SMC_CMD_WRITE,
      SMC_CMD_PRECHARGE,
      SMC_CMD_REFRESH,
      SMC_CMD_STOP,
      SMC_CMD_MODE
   } smc_cmd_t;
   // {cs_n, ras_n, cas_n, we_n}
   function automatic logic [3:0] smc_encode(input smc_cmd_t c);
      unique case (c)
         SMC_CMD_NOP:       smc_encode = 4'h7;
         SMC_CMD_ACTIVE:    smc_encode = 4'h3;
         SMC_CMD_READ:      smc_encode = 4'h5;
         SMC_CMD_WRITE:     smc_encode = 4'h4;
         SMC_CMD_PRECHARGE: smc_encode = 4'h2;
         SMC_CMD_REFRESH:   smc_encode = 4'h1;
         SMC_CMD_STOP:      smc_encode = 4'h6;
         SMC_CMD_MODE:      smc_encode = 4'h0;
      endcase
   endfunction
endpackage
`default_nettype wire

// File: design/smc_gap_timer.sv
// down counter that holds off one class of command
`timescale 1ns/1ps
`default_nettype none
module smc_gap_timer #(
   parameter int W = 4
) (
   input wire logic i_clk_sys, // system clock
   input wire logic i_reset, // sync reset, high
   input wire logic i_load, // start the gap
   input wire logic [W-1:0] i_count, // cycles to hold off
   output logic o_busy // gap still running
);
   logic [W-1:0] cnt_q;
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         cnt_q <= '0;
      end else if (i_load) begin
         cnt_q <= i_count;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end
   assign o_busy = (cnt_q != '0);
endmodule // smc_gap_timer
`default_nettype wire

// File: design/smc_ctrl.sv
// host-side sdram module command sequencer with gap enforcement
//
// Summary of operation
// - column commands may issue every cycle
// - first write data with write command
// - wait after auto-precharge write before activate
// - precharge two cycles after last write data
// - burst stop one cycle after write data
// - new column command one cycle after write
// - three cycles after mode load
// - power-up pause then two refreshes
// - repeat wake refreshes after refresh lapse
// - clock toggles through self refresh exit
// - clock held constant, gate for slowing
// - wait exit gap before activate
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"
module smc_ctrl import smc_pkg::*; #(
   parameter int DW = 64,
   parameter int MW = 8,
   parameter int AW = 13,
   parameter int BW = 2,
   parameter int POWERUP_CYC = `SMC_POWERUP_WAIT_CYC
) (
   input wire logic i_clk_sys, // system clock
   input wire logic i_reset, // sync reset, high
   input wire smc_cmd_t i_cmd, // requested command
   input wire logic [BW-1:0] i_bank, // bank
   input wire logic [AW-1:0] i_addr, // row/column/mode
   input wire logic i_auto_pre, // auto precharge on column cmd
   input wire logic [DW-1:0] i_wdata, // write data with write cmd
   input wire logic [MW-1:0] i_mask, // byte mask, same cycle
   input wire logic i_self_refresh, // hold self refresh
   input wire logic i_refresh_lapsed, // refresh period exceeded
   input wire logic [DW-1:0] i_dq, // data pins in
   output logic o_cmd_ready, // command taken this cycle
   output logic o_init_done, // wake sequence done
   output logic [3:0] o_cmd_n, // cs_n ras_n cas_n we_n
   output logic o_cke, // clock gate
   output logic [BW-1:0] o_ba, // bank pins
   output logic [AW-1:0] o_a, // address pins
   output logic [MW-1:0] o_dqm, // byte mask pins
   output logic [DW-1:0] o_dq, // data pins out
   output logic o_dq_oe, // data pin drive enable
   output logic [DW-1:0] o_rdata // captured read data
);
   typedef enum logic [2:0] {
      SMC_ST_PAUSE, SMC_ST_WAKE, SMC_ST_RUN, SMC_ST_SELF, SMC_ST_EXIT
   } smc_state_t;

   localparam int PW = $clog2(POWERUP_CYC + 1);
   localparam logic [`SMC_GAP_W-1:0] GAP_ACT = `SMC_GAP_W'(`SMC_WRITE_TO_ACTIVATE_GAP);
   localparam logic [`SMC_GAP_W-1:0] GAP_PRE = `SMC_GAP_W'(`SMC_LAST_WRITE_TO_PRECHARGE_GAP);
   localparam logic [`SMC_GAP_W-1:0] GAP_MODE = `SMC_GAP_W'(`SMC_MODE_LOAD_GAP);
   localparam logic [`SMC_GAP_W-1:0] GAP_SELF = `SMC_GAP_W'(`SMC_SELF_REFRESH_EXIT_CYC);

   smc_state_t state_q;
   logic [PW-1:0] wait_q;
   logic [1:0] wake_q;
   logic [DW-1:0] dq_s1_q, dq_s2_q;
   logic act_busy, pre_busy, mode_busy;
   logic take;
   logic is_write, is_col;

   // ------------------------------------------------------------
   // gap timers
   // ------------------------------------------------------------
   assign is_write = take && (i_cmd == SMC_CMD_WRITE);
   assign is_col = take && (i_cmd == SMC_CMD_READ || i_cmd == SMC_CMD_WRITE);

   smc_gap_timer #(.W(`SMC_GAP_W)) u_act_gap (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_load((is_write && i_auto_pre) || (take && i_cmd == SMC_CMD_MODE)
              || (state_q == SMC_ST_SELF && !i_self_refresh)),
      .i_count((take && i_cmd == SMC_CMD_MODE) ? GAP_MODE :
               (state_q == SMC_ST_SELF) ? GAP_SELF : GAP_ACT),
      .o_busy(act_busy)
   );
   smc_gap_timer #(.W(`SMC_GAP_W)) u_pre_gap (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_load(is_write),
      .i_count(GAP_PRE),
      .o_busy(pre_busy)
   );
   // stop and new column command after single-word write need one cycle,
   // which the one-command-per-cycle issue already gives
   assign mode_busy = 1'b0;

   // ------------------------------------------------------------
   // command acceptance
   // ------------------------------------------------------------
   always_comb begin
      take = 1'b0;
      if (state_q == SMC_ST_RUN && !i_self_refresh && !i_refresh_lapsed) begin
         unique case (i_cmd)
            SMC_CMD_ACTIVE, SMC_CMD_REFRESH: take = !act_busy;
            SMC_CMD_PRECHARGE: take = !pre_busy;
            SMC_CMD_STOP: take = !mode_busy;
            SMC_CMD_READ, SMC_CMD_WRITE: take = 1'b1;
            SMC_CMD_MODE: take = !act_busy;
            SMC_CMD_NOP: take = 1'b0;
         endcase
      end
   end
   assign o_cmd_ready = take;
   assign o_init_done = (state_q == SMC_ST_RUN);

   // ------------------------------------------------------------
   // wake and self refresh sequencing
   // ------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         state_q <= SMC_ST_PAUSE;
         wait_q <= '0;
         wake_q <= '0;
      end else begin
         unique case (state_q)
            SMC_ST_PAUSE: begin
               if (wait_q == PW'(POWERUP_CYC - 1)) begin
                  state_q <= SMC_ST_WAKE;
                  wake_q <= '0;
                  wait_q <= '0;
               end else begin
                  wait_q <= wait_q + 1'b1;
               end
            end
            SMC_ST_WAKE: begin
               if (!act_busy) begin
                  if (wake_q == 2'(`SMC_WAKE_REFRESHES - 1)) begin
                     state_q <= SMC_ST_RUN;
                  end
                  wake_q <= wake_q + 1'b1;
               end
            end
            SMC_ST_RUN: begin
               if (i_refresh_lapsed) begin
                  state_q <= SMC_ST_WAKE;
                  wake_q <= '0;
               end else if (i_self_refresh && !act_busy && !pre_busy) begin
                  state_q <= SMC_ST_SELF;
               end
            end
            SMC_ST_SELF: begin
               if (!i_self_refresh) begin
                  state_q <= SMC_ST_EXIT;
               end
            end
            SMC_ST_EXIT: begin
               if (!act_busy) begin
                  state_q <= SMC_ST_RUN;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // pin drive, all registered on the rising edge
   // ------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_cmd_n <= smc_encode(SMC_CMD_NOP);
         o_ba <= '0;
         o_a <= '0;
      end else if (take) begin
         o_cmd_n <= smc_encode(i_cmd);
         o_ba <= i_bank;
         o_a <= i_addr;
         if (is_col) begin
            o_a[`SMC_AUTO_PRE_BIT] <= i_auto_pre;
         end
      end else if (state_q == SMC_ST_WAKE && !act_busy) begin
         o_cmd_n <= smc_encode(SMC_CMD_REFRESH);
      end else if (state_q == SMC_ST_RUN && i_self_refresh && !act_busy && !pre_busy) begin
         o_cmd_n <= smc_encode(SMC_CMD_REFRESH);
      end else begin
         o_cmd_n <= smc_encode(SMC_CMD_NOP);
      end
   end

   // clock stays running; only the gate drops for self refresh
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_cke <= 1'b1;
      end else if (state_q == SMC_ST_RUN && i_self_refresh && !act_busy && !pre_busy) begin
         o_cke <= 1'b0;
      end else if (state_q == SMC_ST_SELF && !i_self_refresh) begin
         o_cke <= 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_dq <= '0;
         o_dq_oe <= 1'b0;
         o_dqm <= '0;
      end else begin
         o_dq <= i_wdata;
         o_dq_oe <= is_write;
         o_dqm <= i_mask;
      end
   end

   // device float timings need no host action beyond the gaps
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         dq_s1_q <= '0;
         dq_s2_q <= '0;
         o_rdata <= '0;
      end else begin
         dq_s1_q <= i_dq;
         dq_s2_q <= dq_s1_q;
         o_rdata <= dq_s2_q;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_WRITE_DATA_WITH_CMD: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      is_write |=> (o_dq_oe && o_cmd_n == smc_encode(SMC_CMD_WRITE) && o_dq == $past(i_wdata)))
      else $error("write data not with write command");
   AST_PRE_AFTER_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      is_write |=> !(take && i_cmd == SMC_CMD_PRECHARGE))
      else $error("precharge too soon after write");
   AST_ACT_AFTER_AP_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      (is_write && i_auto_pre) |=> !(take && i_cmd == SMC_CMD_ACTIVE) [*4])
      else $error("activate too soon after auto precharge write");
   AST_MODE_GAP: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      (take && i_cmd == SMC_CMD_MODE) |=> !(take && i_cmd == SMC_CMD_ACTIVE) [*2])
      else $error("activate too soon after mode load");
   AST_COL_BACK_TO_BACK: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      (state_q == SMC_ST_RUN && !i_self_refresh && !i_refresh_lapsed
       && i_cmd == SMC_CMD_READ) |-> take)
      else $error("column command refused");
   AST_GATE_LOW_IN_SELF: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      (state_q == SMC_ST_SELF) |-> !o_cke)
      else $error("clock gate high in self refresh");
   AST_NO_CMD_IN_PAUSE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      (state_q == SMC_ST_PAUSE) |-> !take)
      else $error("command during power-up pause");
   AST_MASK_SAME_CYCLE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
      1'b1 |=> (o_dqm == $past(i_mask)))
      else $error("mask not aligned with data");
endmodule // smc_ctrl
`default_nettype wire

// File: testbench/smc_sdram_model.sv
// behavioural sdram module seen from the controller pins
`timescale 1ns/1ps
`default_nettype none
module smc_sdram_model #(
   parameter int DW = 64,
   parameter int RL = 2 // read_latency
) (
   input wire logic i_clk_sys, // system clock
   input wire logic [3:0] i_cmd_n, // command pins
   input wire logic i_cke, // clock gate
   input wire logic [DW/8-1:0] i_dqm, // byte mask
   input wire logic [DW-1:0] i_dq, // data from controller
   output logic [DW-1:0] o_dq // data to controller
);
   logic [DW-1:0] mem_q = '0;
   logic [RL:0] rd_q = '0;
   logic [1:0] mq_q = '0;
   logic cke_q = 1'b1;
   logic [15:0] self_q = '0;
   logic [DW-1:0] dq_q = '1;
   assign o_dq = dq_q;
   // ---------------
   // pin behaviour
   // ---------------
   always @(posedge i_clk_sys) begin
      cke_q <= i_cke;
      rd_q <= {rd_q[RL-1:0], cke_q && i_cmd_n == 4'h5};
      if (cke_q && i_cmd_n == 4'h4)
         for (int b = 0; b < DW/8; b++)
            if (!i_dqm[b]) mem_q[b*8 +: 8] <= i_dq[b*8 +: 8];
      if (!i_cke) self_q <= self_q + 16'h1;
      mq_q <= {mq_q[0], |i_dqm};
      // released bus shows the inverse, so a stale word never looks valid
      dq_q <= (rd_q[RL-1] && !mq_q[1]) ? mem_q : ~mem_q;
   end
endmodule // smc_sdram_model
`default_nettype wire

// File: testbench/sdram_module_command_timing_tb_top.sv
// self-checking bench for the sdram module controller
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"
module sdram_module_command_timing_tb_top import smc_pkg::*;;
   localparam int PU = 10;
   logic i_clk_sys = 1'b0;
   logic i_reset = 1'b1;
   smc_cmd_t i_cmd = SMC_CMD_NOP;
   logic [12:0] i_addr = '0;
   logic i_auto_pre = 1'b0;
   logic i_self_refresh = 1'b0;
   logic i_refresh_lapsed = 1'b0;
   logic [63:0] i_wdata = '0;
   logic [63:0] i_dq, o_dq, o_rdata;
   logic [7:0] i_mask = '0;
   logic [7:0] o_dqm;
   logic o_cmd_ready, o_init_done, o_cke, o_dq_oe;
   logic [3:0] o_cmd_n;
   logic [12:0] o_a;
   logic [1:0] o_ba;
   int errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int t1, t2, t3, n, r;
   always #10 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) cyc <= cyc + 1;
   smc_ctrl #(.POWERUP_CYC(PU)) i_dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
      .i_cmd(i_cmd), .i_bank(2'h1), .i_addr(i_addr), .i_auto_pre(i_auto_pre),
      .i_wdata(i_wdata), .i_mask(i_mask), .i_self_refresh(i_self_refresh),
      .i_refresh_lapsed(i_refresh_lapsed), .i_dq(i_dq), .o_cmd_ready(o_cmd_ready),
      .o_init_done(o_init_done), .o_cmd_n(o_cmd_n), .o_cke(o_cke), .o_ba(o_ba),
      .o_a(o_a), .o_dqm(o_dqm), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_rdata(o_rdata));
   smc_sdram_model i_mem (.i_clk_sys(i_clk_sys), .i_cmd_n(o_cmd_n), .i_cke(o_cke),
      .i_dqm(o_dqm), .i_dq(o_dq), .o_dq(i_dq));
   // ---------------
   // helpers
   // ---------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic ge(input int got, input int least);
      tests_run++;
      if (got < least) begin
         errors++;
         $display("[ERR] %0t gap %h min %h", $time, got, least);
      end
   endtask
   // holds the request until taken, returns the cycle it shows on the pins
   task automatic issue(input smc_cmd_t c, input logic ap, input logic [63:0] d,
                        input logic [7:0] m, output int t);
      int k;
      k = 0;
      i_cmd = c;
      i_auto_pre = ap;
      i_wdata = d;
      i_mask = m;
      #2;
      while (o_cmd_ready !== 1'b1 && k < 50) begin
         @(posedge i_clk_sys);
         #3;
         k++;
      end
      if (k == 50) begin
         errors++;
         $display("[ERR] %0t ready %h exp %h", $time, o_cmd_ready, 1'b1);
      end
      @(posedge i_clk_sys);
      #1;
      t = cyc;
   endtask
   task automatic idle();
      i_cmd = SMC_CMD_NOP;
      i_mask = 8'h00;
      @(posedge i_clk_sys);
      #1;
   endtask
   task automatic count_refresh(input int lim, output int refs, output int first);
      refs = 0;
      first = 0;
      for (int k = 1; k <= lim; k++) begin
         @(posedge i_clk_sys);
         #1;
         if (o_cmd_n === 4'h1) begin
            refs++;
            if (first == 0) first = k;
         end
      end
   endtask
   task automatic finish_test();
      if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ---------------
   // scenarios
   // ---------------
   task automatic t_writes();
      issue(SMC_CMD_WRITE, 1'b0, 64'h0123456789ABCDEF, 8'h00, t1);
      issue(SMC_CMD_WRITE, 1'b0, 64'hFEDCBA9876543210, 8'h0F, t2);
      chk(t2 - t1, 1);
      chk({o_cmd_n, o_dq_oe}, {4'h4, 1'b1});
      chk({o_dqm, o_dq}, {8'h0F, 64'hFEDCBA9876543210});
      chk(o_ba, 2'h1);
      issue(SMC_CMD_PRECHARGE, 1'b0, 64'h0, 8'h00, t3);
      ge(t3 - t2, `SMC_LAST_WRITE_TO_PRECHARGE_GAP);
      issue(SMC_CMD_READ, 1'b0, 64'h0, 8'h00, t1);
      idle();
      n = 0;
      while (o_rdata !== 64'hFEDCBA9889ABCDEF && n < 12) begin
         @(posedge i_clk_sys);
         #1;
         n++;
      end
      chk(o_rdata, 64'hFEDCBA9889ABCDEF);
      // masked read: the word must never reach the capture register
      issue(SMC_CMD_READ, 1'b0, 64'h0, 8'hFF, t1);
      idle();
      r = 0;
      repeat (12) begin
         @(posedge i_clk_sys);
         #1;
         if (o_rdata === 64'hFEDCBA9889ABCDEF) r++;
      end
      chk(r, 0);
   endtask
   task automatic t_gaps();
      issue(SMC_CMD_MODE, 1'b0, 64'h0, 8'h00, t1);
      issue(SMC_CMD_ACTIVE, 1'b0, 64'h0, 8'h00, t2);
      ge(t2 - t1, `SMC_MODE_LOAD_GAP);
      issue(SMC_CMD_WRITE, 1'b1, 64'h5A5A, 8'h00, t1);
      chk(o_a[`SMC_AUTO_PRE_BIT], 1'b1);
      issue(SMC_CMD_ACTIVE, 1'b0, 64'h0, 8'h00, t2);
      ge(t2 - t1, `SMC_WRITE_TO_ACTIVATE_GAP);
      idle();
   endtask
   task automatic t_self();
      i_self_refresh = 1'b1;
      n = 0;
      while (o_cke !== 1'b0 && n < 20) begin
         @(posedge i_clk_sys);
         #1;
         n++;
      end
      chk({o_cke, o_cmd_n}, {1'b0, 4'h1});
      repeat (6) @(posedge i_clk_sys);
      #1;
      i_self_refresh = 1'b0;
      n = 0;
      while (o_cke !== 1'b1 && n < 20) begin
         @(posedge i_clk_sys);
         #1;
         n++;
      end
      t1 = cyc;
      issue(SMC_CMD_ACTIVE, 1'b0, 64'h0, 8'h00, t2);
      ge(t2 - t1, `SMC_SELF_REFRESH_EXIT_CYC);
      idle();
   endtask
   initial begin
      #(20 * 5000);
      errors++;
      finish_test();
   end
   initial begin
      repeat (16) @(posedge i_clk_sys);
      #1;
      chk({o_cmd_n, o_cke, o_dq_oe}, {4'h7, 1'b1, 1'b0});
      i_reset = 1'b0;
      count_refresh(PU + 40, r, n);
      chk(r, `SMC_WAKE_REFRESHES);
      ge(n, PU);
      chk(o_init_done, 1'b1);
      t_writes();
      t_gaps();
      t_self();
      i_refresh_lapsed = 1'b1;
      @(posedge i_clk_sys);
      #1;
      i_refresh_lapsed = 1'b0;
      count_refresh(30, r, n);
      chk(r, `SMC_WAKE_REFRESHES);
      finish_test();
   end
endmodule // sdram_module_command_timing_tb_top
`default_nettype wire
